// ==== hw/ncp_regs.vh ====
// Message identifiers, field offsets and timing constants for the payload packer
`ifndef NCP_REGS_VH
`define NCP_REGS_VH
`define NCP_ID_DATE_TIME 11'h600
`define NCP_ID_LAT_LON 11'h601
`define NCP_ID_ALTITUDE 11'h602
`define NCP_ID_NED_VEL 11'h603
`define NCP_ID_LEVEL_VEL 11'h604
`define NCP_ID_VEH_ACCEL 11'h605
`define NCP_ID_LEVEL_ACCEL 11'h606
`define NCP_ID_ORIENT 11'h607
`define NCP_ID_VEH_RATE 11'h608
`define NCP_ID_LEVEL_RATE 11'h609
`define NCP_ID_TRACK_SLIP 11'h60A
`define NCP_NUM_MSG 11
`define NCP_DLC 4'h8
`define NCP_OFS_W0 0
`define NCP_OFS_W1 16
`define NCP_OFS_W2 32
`define NCP_OFS_W3 48
`define NCP_OFS_L0 0
`define NCP_OFS_L1 32
`define NCP_HEADING_MAX 16'h8C9F
`define NCP_PITCH_MAX 16'h2328
`define NCP_ROLL_MAX 16'h4650
`define NCP_GPS_UTC_S 16
`define NCP_RESET_PAYLOAD 64'h0
`define NCP_LAST_IDX 4'hA
`define NCP_IDX_SPEED 4'h3
`define NCP_ROOT_TOP 5'h10
`define NCP_SPEED_SAT 16'h7FFF
`endif

// ==== hw/ncp_mag.v ====
// Iterative magnitude of two signed 16-bit components
`timescale 1ns/100ps
`include "ncp_regs.vh"
module ncp_mag (
  clk,
  resetn,
  start,
  a_in,
  b_in,
  done,
  mag
);
  input wire clk;
  input wire resetn;
  input wire start;
  input wire [15:0] a_in;
  input wire [15:0] b_in;
  output reg done;
  output reg [15:0] mag;

  reg [33:0] rem_reg;
  reg [16:0] root_reg;
  reg [4:0] cnt_reg;
  reg busy_reg;
  wire [15:0] abs_a;
  wire [15:0] abs_b;
  wire [31:0] sq_a;
  wire [31:0] sq_b;
  wire [33:0] sumsq;
  wire [33:0] trial;

  assign abs_a = a_in[15] ? (16'h0000 - a_in) : a_in;
  assign abs_b = b_in[15] ? (16'h0000 - b_in) : b_in;
  // Squares widened first; inside a concatenation they would keep only 16 bits
  assign sq_a = {16'h0000, abs_a} * {16'h0000, abs_a};
  assign sq_b = {16'h0000, abs_b} * {16'h0000, abs_b};
  assign sumsq = {2'b00, sq_a} + {2'b00, sq_b};
  assign trial = ({17'h00000, root_reg} | (34'h1 << cnt_reg)) * ({17'h00000, root_reg} | (34'h1 << cnt_reg));

  // Bit-serial square root: one result bit per cycle, saves a big divider
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rem_reg <= 34'h0;
      root_reg <= 17'h0;
      cnt_reg <= 5'h0;
      busy_reg <= 1'b0;
      done <= 1'b0;
      mag <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (start && !busy_reg) begin
        rem_reg <= sumsq;
        root_reg <= 17'h0;
        cnt_reg <= `NCP_ROOT_TOP;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (trial <= rem_reg)
          root_reg <= root_reg | (17'h1 << cnt_reg);
        if (cnt_reg == 5'h0) begin
          busy_reg <= 1'b0;
          done <= 1'b1;
          // Saturate: magnitude can exceed the signed 16-bit range
          if ((root_reg | ((trial <= rem_reg) ? 17'h1 : 17'h0)) > {1'b0, `NCP_SPEED_SAT})
            mag <= `NCP_SPEED_SAT;
          else
            mag <= root_reg[15:0] | ((trial <= rem_reg) ? 16'h0001 : 16'h0000);
        end else begin
          cnt_reg <= cnt_reg - 5'h1;
        end
      end
    end
  end
endmodule

// ==== hw/ncp_packer.v ====
// Navigation measurement to CAN payload packer
`timescale 1ns/100ps
`include "ncp_regs.vh"

module ncp_packer (
  clk,
  resetn,
  sample_valid,
  alt_ellipsoid_sel,
  year_in_century,
  century_field,
  month_field,
  day_field,
  hundredths_second,
  second_field,
  minute_field,
  hour_field,
  latitude_field,
  longitude_field,
  altitude_msl,
  altitude_ellipsoid,
  north_velocity,
  east_velocity,
  down_velocity,
  level_forward_velocity,
  level_lateral_velocity,
  veh_accel_x,
  veh_accel_y,
  veh_accel_z,
  level_accel_fwd,
  level_accel_lat,
  level_accel_down,
  slip_rate_field,
  heading_field,
  pitch_field,
  roll_field,
  body_rate_x,
  veh_rate_y,
  veh_rate_z,
  level_rate_fwd,
  level_rate_lat,
  level_rate_down,
  track_angle_field,
  slip_angle_field,
  curvature_field,
  frame_ready,
  busy,
  frame_valid,
  frame_id,
  frame_dlc,
  frame_data
);
  input wire clk;
  input wire resetn;
  input wire sample_valid;
  input wire alt_ellipsoid_sel;
  input wire [7:0] year_in_century;
  input wire [7:0] century_field;
  input wire [7:0] month_field;
  input wire [7:0] day_field;
  input wire [7:0] hundredths_second;
  input wire [7:0] second_field;
  input wire [7:0] minute_field;
  input wire [7:0] hour_field;
  input wire [31:0] latitude_field;
  input wire [31:0] longitude_field;
  input wire [31:0] altitude_msl;
  input wire [31:0] altitude_ellipsoid;
  input wire [15:0] north_velocity;
  input wire [15:0] east_velocity;
  input wire [15:0] down_velocity;
  input wire [15:0] level_forward_velocity;
  input wire [15:0] level_lateral_velocity;
  input wire [15:0] veh_accel_x;
  input wire [15:0] veh_accel_y;
  input wire [15:0] veh_accel_z;
  input wire [15:0] level_accel_fwd;
  input wire [15:0] level_accel_lat;
  input wire [15:0] level_accel_down;
  input wire [15:0] slip_rate_field;
  input wire [15:0] heading_field;
  input wire [15:0] pitch_field;
  input wire [15:0] roll_field;
  input wire [15:0] body_rate_x;
  input wire [15:0] veh_rate_y;
  input wire [15:0] veh_rate_z;
  input wire [15:0] level_rate_fwd;
  input wire [15:0] level_rate_lat;
  input wire [15:0] level_rate_down;
  input wire [15:0] track_angle_field;
  input wire [15:0] slip_angle_field;
  input wire [15:0] curvature_field;
  input wire frame_ready;
  output reg busy;
  output reg frame_valid;
  output reg [10:0] frame_id;
  output reg [3:0] frame_dlc;
  output reg [63:0] frame_data;

  localparam ST_IDLE = 3'b001;
  localparam ST_MAG = 3'b010;
  localparam ST_SEND = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [3:0] idx_reg;
  reg [3:0] idx_next;
  reg mag_start_reg;
  reg [15:0] speed_reg;
  // Snapshot of one sample set so every frame of a cycle is coherent
  reg [63:0] snap_reg [0:`NCP_NUM_MSG-1];
  reg [63:0] pay [0:`NCP_NUM_MSG-1];
  reg [15:0] hdg_c;
  reg [15:0] pit_c;
  reg [15:0] rol_c;
  wire mag_done;
  wire [15:0] mag_val;
  wire accept;
  wire [15:0] snap_north;
  wire [15:0] snap_east;
  wire [31:0] altitude_sel;
  reg load_frame;
  reg frame_valid_next;
  reg [10:0] frame_id_next;
  reg [3:0] frame_dlc_next;
  reg [63:0] frame_data_next;

  assign accept = sample_valid && (state_reg == ST_IDLE);

  // Root reads the captured velocities, not the live pins, so 603h stays coherent
  assign snap_north = snap_reg[`NCP_IDX_SPEED][15:0];
  assign snap_east = snap_reg[`NCP_IDX_SPEED][31:16];

  // Datum chosen per sample; mean sea level unless the ellipsoid is asked
  assign altitude_sel = alt_ellipsoid_sel ? altitude_ellipsoid : altitude_msl;

  ncp_mag u_mag (
    .clk(clk),
    .resetn(resetn),
    .start(mag_start_reg),
    .a_in(snap_north),
    .b_in(snap_east),
    .done(mag_done),
    .mag(mag_val)
  );

  // Heading is unsigned, so only the top of its range needs a limit
  always @* begin
    hdg_c = (heading_field > `NCP_HEADING_MAX) ? `NCP_HEADING_MAX : heading_field;
  end

  // Pitch clamps symmetric about zero; wrap is not attempted
  always @* begin
    pit_c = pitch_field;
    if ($signed(pitch_field) > $signed(`NCP_PITCH_MAX))
      pit_c = `NCP_PITCH_MAX;
    else if ($signed(pitch_field) < -$signed(`NCP_PITCH_MAX))
      pit_c = 16'h0000 - `NCP_PITCH_MAX;
  end

  // Roll clamps symmetric about zero as well
  always @* begin
    rol_c = roll_field;
    if ($signed(roll_field) > $signed(`NCP_ROLL_MAX))
      rol_c = `NCP_ROLL_MAX;
    else if ($signed(roll_field) < -$signed(`NCP_ROLL_MAX))
      rol_c = 16'h0000 - `NCP_ROLL_MAX;
  end

  // Payload assembly; vectors are LSB-first so byte 0 is bits 7:0
  always @* begin
    // GPS time passes straight through, no UTC offset applied
    pay[0] = {hour_field, minute_field, second_field, hundredths_second,
      day_field, month_field, century_field, year_in_century};
    pay[1] = {longitude_field, latitude_field};
    pay[2] = {32'h00000000, altitude_sel};
    pay[3] = {16'h0000, down_velocity, east_velocity, north_velocity};
    pay[4] = {32'h00000000, level_lateral_velocity, level_forward_velocity};
    pay[5] = {16'h0000, veh_accel_z, veh_accel_y, veh_accel_x};
    pay[6] = {slip_rate_field, level_accel_down, level_accel_lat, level_accel_fwd};
    pay[7] = {16'h0000, rol_c, pit_c, hdg_c};
    pay[8] = {16'h0000, veh_rate_z, veh_rate_y, body_rate_x};
    pay[9] = {16'h0000, level_rate_down, level_rate_lat, level_rate_fwd};
    pay[10] = {16'h0000, curvature_field, slip_angle_field, track_angle_field};
  end

  // Snapshot registers, one per message; raw values carry no offset
  genvar gi;
  generate
    for (gi = 0; gi < `NCP_NUM_MSG; gi = gi + 1) begin : g_snap
      always @(posedge clk or negedge resetn) begin
        if (!resetn)
          snap_reg[gi] <= `NCP_RESET_PAYLOAD;
        else if (accept)
          snap_reg[gi] <= pay[gi];
      end
    end
  endgenerate

  // Sequencer: wait for the speed root, then send 600h..60Ah in order
  always @* begin
    state_next = state_reg;
    idx_next = idx_reg;
    case (state_reg)
      ST_IDLE: begin
        if (sample_valid) begin
          state_next = ST_MAG;
          idx_next = 4'h0;
        end
      end
      ST_MAG: begin
        if (mag_done)
          state_next = ST_SEND;
      end
      ST_SEND: begin
        if (frame_valid && frame_ready) begin
          if (idx_reg == `NCP_LAST_IDX)
            state_next = ST_IDLE;
          else
            idx_next = idx_reg + 4'h1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State, index and the one-cycle root start pulse
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      idx_reg <= 4'h0;
      mag_start_reg <= 1'b0;
      speed_reg <= 16'h0000;
      busy <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      mag_start_reg <= accept;
      if (mag_done)
        speed_reg <= mag_val;
      busy <= (state_next != ST_IDLE);
    end
  end

  // Next frame contents; idle slots read as zero so no stale word lingers
  always @* begin
    // A new frame may load only when the slot is empty or being taken
    load_frame = !frame_valid || frame_ready;
    frame_valid_next = (state_next == ST_SEND);
    frame_id_next = 11'h000;
    frame_dlc_next = 4'h0;
    frame_data_next = `NCP_RESET_PAYLOAD;
    if (state_next == ST_SEND) begin
      frame_id_next = `NCP_ID_DATE_TIME + {7'h00, idx_next};
      frame_dlc_next = `NCP_DLC;
      // Speed is ready long before 603h is reached, so the register suffices
      if (idx_next == `NCP_IDX_SPEED)
        frame_data_next = {speed_reg, snap_reg[`NCP_IDX_SPEED][47:0]};
      else
        frame_data_next = snap_reg[idx_next];
    end
  end

  // Output frame register; holds steady while the receiver stalls
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_valid <= 1'b0;
      frame_id <= 11'h000;
      frame_dlc <= 4'h0;
      frame_data <= `NCP_RESET_PAYLOAD;
    end else if (load_frame) begin
      frame_valid <= frame_valid_next;
      frame_id <= frame_id_next;
      frame_dlc <= frame_dlc_next;
      frame_data <= frame_data_next;
    end
  end
endmodule

// ==== verif/ncp_packer_props.sv ====
// Checker for the payload packer output handshake
`timescale 1ns/100ps
module ncp_chk (
  input wire clk,
  input wire resetn,
  input wire sample_valid,
  input wire frame_ready,
  input wire busy,
  input wire frame_valid,
  input wire [10:0] frame_id,
  input wire [3:0] frame_dlc,
  input wire [63:0] frame_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Sample taken, and frame handed over
  sequence s_take;
    sample_valid && !busy;
  endsequence
  sequence s_hand;
    frame_valid && frame_ready;
  endsequence
  property p_lat;
    s_take |-> ##[19:22] $rose(frame_valid);
  endproperty
  a_lat: assert property (p_lat) else $error("first frame late");
  property p_first;
    $rose(busy) |-> ##[18:21] (frame_valid && frame_id == 11'h600);
  endproperty
  a_first: assert property (p_first) else $error("burst not opened by 600h");
  property p_hold;
    frame_valid && !frame_ready |=> frame_valid && $stable(frame_id) && $stable(frame_data);
  endproperty
  a_hold: assert property (p_hold) else $error("frame changed unaccepted");
  property p_dlc;
    frame_valid |-> frame_dlc == 4'h8;
  endproperty
  a_dlc: assert property (p_dlc) else $error("length not eight");
  property p_next;
    s_hand ##0 (frame_id != 11'h60A) |=> frame_valid && frame_id == $past(frame_id) + 11'h1;
  endproperty
  a_next: assert property (p_next) else $error("identifier not advanced");
  property p_last;
    s_hand ##0 (frame_id == 11'h60A) |=> !frame_valid && !busy;
  endproperty
  a_last: assert property (p_last) else $error("burst not closed");
  property p_idle;
    !busy |-> !frame_valid;
  endproperty
  a_idle: assert property (p_idle) else $error("frame while idle");
  property p_head;
    frame_valid && frame_id == 11'h607 |-> frame_data[15:0] <= 16'h8C9F && !(|frame_data[63:48]);
  endproperty
  a_head: assert property (p_head) else $error("heading out of range");
  property p_speed;
    frame_valid && frame_id == 11'h603 |-> !frame_data[63];
  endproperty
  a_speed: assert property (p_speed) else $error("negative speed");
endmodule
bind ncp_packer ncp_chk i_chk (.clk, .resetn, .sample_valid, .frame_ready, .busy,
  .frame_valid, .frame_id, .frame_dlc, .frame_data);

// ==== verif/ncp_rx_model.sv ====
// Frame receiver model that records every accepted frame
`timescale 1ns/100ps
module ncp_rx_model (
  input wire clk,
  input wire resetn,
  input wire stall,
  input wire frame_valid,
  input wire [10:0] frame_id,
  input wire [3:0] frame_dlc,
  input wire [63:0] frame_data,
  output logic frame_ready
);
  logic [78:0] rec [0:127];
  int n = 0;
  logic [1:0] cnt_reg;
  // Ready every edge, or one edge in four to make the packer wait
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 2'h0;
      frame_ready <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      frame_ready <= !stall || cnt_reg == 2'h3;
    end
  end
  // Raw words kept; decode is raw times factor with no offset
  always @(posedge clk) begin
    if (resetn && frame_valid && frame_ready) begin
      rec[n] <= {frame_dlc, frame_id, frame_data};
      n <= n + 1;
    end
  end
endmodule

// ==== verif/ncp_packer_tb.sv ====
// Self-checking bench for the payload packer
`timescale 1ns/100ps
`include "ncp_regs.vh"
module ncp_packer_tb;
  logic clk, resetn, sample_valid, alt_ellipsoid_sel, frame_ready, stall;
  logic [7:0] year_in_century, century_field, month_field, day_field;
  logic [7:0] hundredths_second, second_field, minute_field, hour_field;
  logic [31:0] latitude_field, longitude_field, altitude_msl, altitude_ellipsoid;
  logic [15:0] north_velocity, east_velocity, down_velocity, level_forward_velocity;
  logic [15:0] level_lateral_velocity, veh_accel_x, veh_accel_y, veh_accel_z;
  logic [15:0] level_accel_fwd, level_accel_lat, level_accel_down, slip_rate_field;
  logic [15:0] heading_field, pitch_field, roll_field, body_rate_x, veh_rate_y;
  logic [15:0] veh_rate_z, level_rate_fwd, level_rate_lat, level_rate_down;
  logic [15:0] track_angle_field, slip_angle_field, curvature_field;
  wire busy, frame_valid;
  wire [10:0] frame_id;
  wire [3:0] frame_dlc;
  wire [63:0] frame_data;
  logic [495:0] pat;
  int mismatches = 0;
  int total_checks = 0;
  // North, east, heading, pitch, roll in; speed and clamped angles out
  logic [143:0] rows [0:3] = '{
    144'h0BB8_0FA0_04D2_0100_FF00_1388_04D2_0100_FF00,
    144'hFED4_0190_8CA0_2329_4651_01F4_8C9F_2328_4650,
    144'h8000_8000_FFFF_DCD7_B9AF_7FFF_8C9F_DCD8_B9B0,
    144'h0000_0000_8C9F_2328_B9B0_0000_8C9F_2328_B9B0};
  assign {year_in_century, century_field, month_field, day_field, hundredths_second,
    second_field, minute_field, hour_field, latitude_field, longitude_field, altitude_msl,
    altitude_ellipsoid, down_velocity, level_forward_velocity, level_lateral_velocity,
    veh_accel_x, veh_accel_y, veh_accel_z, level_accel_fwd, level_accel_lat,
    level_accel_down, slip_rate_field, body_rate_x, veh_rate_y, veh_rate_z, level_rate_fwd,
    level_rate_lat, level_rate_down, track_angle_field, slip_angle_field,
    curvature_field} = pat;
  ncp_packer i_dut (.*);
  ncp_rx_model i_rx (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [78:0] seen, input logic [78:0] want);
    total_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Every lane distinct so a swapped field shows; upper rows go negative
  task automatic load(input int r);
    for (int i = 0; i < 31; i++) pat[16*i+:16] = {r[1:0], i[5:0], ~i[7:0]};
    {north_velocity, east_velocity, heading_field, pitch_field, roll_field} = rows[r][143:64];
    alt_ellipsoid_sel = r[0];
    stall = r[0];
  endtask
  function automatic logic [63:0] expect_word(input int k, input int r);
    case (k)
      0: return {hour_field, minute_field, second_field, hundredths_second, day_field,
        month_field, century_field, year_in_century};
      1: return {longitude_field, latitude_field};
      2: return {32'h0, alt_ellipsoid_sel ? altitude_ellipsoid : altitude_msl};
      3: return {rows[r][63:48], down_velocity, east_velocity, north_velocity};
      4: return {32'h0, level_lateral_velocity, level_forward_velocity};
      5: return {16'h0, veh_accel_z, veh_accel_y, veh_accel_x};
      6: return {slip_rate_field, level_accel_down, level_accel_lat, level_accel_fwd};
      7: return {16'h0, rows[r][15:0], rows[r][31:16], rows[r][47:32]};
      8: return {16'h0, veh_rate_z, veh_rate_y, body_rate_x};
      9: return {16'h0, level_rate_down, level_rate_lat, level_rate_fwd};
      default: return {16'h0, curvature_field, slip_angle_field, track_angle_field};
    endcase
  endfunction
  task automatic do_reset;
    resetn = 1'b0;
    repeat (4) @(negedge clk);
    check(79'({frame_valid, busy, frame_id, frame_data}), 79'h0);
    resetn = 1'b1;
  endtask
  // Mode 1 offers a second sample while busy, mode 2 stops after the pulse
  task automatic run(input int r, input int mode);
    int base;
    base = i_rx.n;
    load(r);
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
    if (mode == 1) begin
      pat = ~pat;
      {north_velocity, east_velocity} = ~{north_velocity, east_velocity};
      sample_valid = 1'b1;
      @(negedge clk);
      sample_valid = 1'b0;
      pat = ~pat;
      {north_velocity, east_velocity} = ~{north_velocity, east_velocity};
    end
    if (mode == 2) return;
    for (int t = 0; t < 300 && i_rx.n < base + 11; t++) @(negedge clk);
    if (i_rx.n < base + 11) begin
      mismatches++;
      complete_run();
    end
    repeat (30) @(negedge clk);
    check(79'(i_rx.n - base), 79'hB);
    check(79'(busy), 79'h0);
    for (int k = 0; k < 11; k++)
      check(i_rx.rec[base + k], {`NCP_DLC, 11'(`NCP_ID_DATE_TIME + k), expect_word(k, r)});
  endtask
  initial begin
    {resetn, sample_valid, alt_ellipsoid_sel, stall, pat} = '0;
    {north_velocity, east_velocity, heading_field, pitch_field, roll_field} = '0;
    @(negedge clk);
    do_reset();
    for (int r = 0; r < 4; r++) run(r, 0);
    run(0, 1);
    // Reset in mid-burst, then a clean burst
    run(1, 2);
    repeat (24) @(negedge clk);
    do_reset();
    run(1, 0);
    complete_run();
  end
endmodule
